// ===== rtl/bmw_write_path.sv
// Purpose: Byte-lane masked two-word burst write port with array and read launch
// Assumes: kClk/kClkN and cClk/cClkN are complementary pairs; core_clk unrelated
// Notes:   Bursts that meet a full buffer are dropped and flagged on the core side
module bmw_write_path #(
  parameter int DATA_W = bmw_pkg::DATA_W_DEFAULT,
  parameter int ADDR_W = bmw_pkg::ADDR_W_DEFAULT
) (
  // Core side
  input  wire logic                                   core_clk,
  input  wire logic                                   rst_b,
  input  wire logic                                   overrunClear,
  output logic                                        overrunFlag,
  output logic                                        writeCommit,
  output logic [$clog2(bmw_pkg::FIFO_DEPTH):0]        pendingBursts,
  // Strap
  input  wire logic                                   singleClockMode,
  // Input clock pair
  input  wire logic                                   kClk,
  input  wire logic                                   kClkN,
  // Output clock pair
  input  wire logic                                   cClk,
  input  wire logic                                   cClkN,
  // Port selects and address
  input  wire logic                                   read_port_select_n,
  input  wire logic                                   write_port_select_n,
  input  wire logic [ADDR_W-1:0]                      addrIn,
  // Write data
  input  wire logic [DATA_W-1:0]                      dataIn,
  input  wire logic [DATA_W/bmw_pkg::LANE_W-1:0]      lane_write_select_n,
  // Read data, launched on the output rise
  output logic [DATA_W-1:0]                           qRiseData,
  output logic                                        qRiseOe,
  // Read data, launched on the complement output rise
  output logic [DATA_W-1:0]                           qFallData,
  output logic                                        qFallOe
);

  localparam int LANES   = DATA_W / bmw_pkg::LANE_W;
  localparam int HALF_W  = DATA_W + LANES;
  localparam int BURST_W = ADDR_W + 2 * HALF_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int LVL_W   = $clog2(bmw_pkg::FIFO_DEPTH) + 1;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                linkRst1_q;
  logic                linkRst2_q;
  logic                linkRstB;
  logic                halfRst1_q;
  logic                halfRst2_q;
  logic                halfRstB;

  logic [ADDR_W-1:0]   wrAddrN_q;
  logic [DATA_W-1:0]   data1N_q;
  logic [LANES-1:0]    mask1N_q;

  logic                wrPend_q;
  logic [DATA_W-1:0]   data0_q;
  logic [LANES-1:0]    mask0_q;
  logic                rdPend_q;
  logic [ADDR_W-1:0]   rdAddr_q;
  logic                rdOut_q;
  logic [DATA_W-1:0]   rdData0_q;
  logic [DATA_W-1:0]   rdData1_q;
  logic                dropToggle_q;
  logic                commitToggle_q;
  logic [LVL_W-1:0]    levelGray_q;

  logic [BURST_W-1:0]  burstIn;
  logic [BURST_W-1:0]  burstOut;
  logic                fillReady;
  logic                drainValid;
  logic                drainReady;
  logic                commit;
  logic                drop;
  logic [LVL_W-1:0]    fifoLevel;
  logic [ADDR_W-1:0]   cmtAddr;
  logic [DATA_W-1:0]   cmtData0;
  logic [LANES-1:0]    cmtMask0;
  logic [DATA_W-1:0]   cmtData1;
  logic [LANES-1:0]    cmtMask1;
  logic [DATA_W-1:0]   arrWord0;
  logic [DATA_W-1:0]   arrWord1;

  logic                launchClk;
  logic                launchClkN;
  logic [DATA_W-1:0]   hold1_q;
  logic                qFallOe_q;
  logic [DATA_W-1:0]   qFallData_q;
  logic                qRiseOe_q;
  logic [DATA_W-1:0]   qRiseData_q;

  logic                dropSync1_q;
  logic                dropSync2_q;
  logic                dropSync3_q;
  logic                cmtSync1_q;
  logic                cmtSync2_q;
  logic                cmtSync3_q;
  logic [LVL_W-1:0]    lvlSync1_q;
  logic [LVL_W-1:0]    lvlSync2_q;
  logic                overrunFlag_q;
  logic                overrunFlag_d;
  logic                writeCommit_q;
  logic [LVL_W-1:0]    pending_q;
  logic [LVL_W-1:0]    pending_d;

  //////////////////////////////////////////////////////////////////////////////
  // Link reset: asserted at once, released on kClk
  always_ff @(posedge kClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRst1_q <= 1'b0;
      linkRst2_q <= 1'b0;
    end else begin
      linkRst1_q <= 1'b1;
      linkRst2_q <= linkRst1_q;
    end
  end
  assign linkRstB = linkRst2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Second-half reset: asserted at once, released on kClkN
  always_ff @(posedge kClkN or negedge rst_b) begin
    if (!rst_b) begin
      halfRst1_q <= 1'b0;
      halfRst2_q <= 1'b0;
    end else begin
      halfRst1_q <= 1'b1;
      halfRst2_q <= halfRst1_q;
    end
  end
  assign halfRstB = halfRst2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Second half of a write, taken on the complement input rise
  always_ff @(posedge kClkN or negedge halfRstB) begin
    if (!halfRstB) begin
      wrAddrN_q <= '0;
      data1N_q  <= '0;
      mask1N_q  <= '1;
    end else begin
      wrAddrN_q <= addrIn;
      data1N_q  <= dataIn;
      mask1N_q  <= lane_write_select_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // First half of a write and read address, taken on the input rise
  always_ff @(posedge kClk or negedge linkRstB) begin
    if (!linkRstB) begin
      wrPend_q <= 1'b0;
      data0_q  <= '0;
      mask0_q  <= '1;
      rdPend_q <= 1'b0;
      rdAddr_q <= '0;
    end else begin
      wrPend_q <= ~write_port_select_n;
      data0_q  <= dataIn;
      mask0_q  <= lane_write_select_n;
      rdPend_q <= ~read_port_select_n;
      rdAddr_q <= addrIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Burst buffer: whole burst enters one input rise after it opened
  assign burstIn = {wrAddrN_q, data1N_q, mask1N_q, data0_q, mask0_q};
  assign drop    = wrPend_q & ~fillReady;

  bmw_fifo #(
    .WIDTH (BURST_W),
    .DEPTH (bmw_pkg::FIFO_DEPTH)
  ) u_burst_fifo (
    .clk      (kClk),
    .rstB     (linkRstB),
    .inValid  (wrPend_q),
    .inReady  (fillReady),
    .inData   (burstIn),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (burstOut),
    .level    (fifoLevel)
  );

  // A read owns the array for its edge, so the commit waits
  assign drainReady = ~rdPend_q;
  assign commit     = drainValid & drainReady;
  assign {cmtAddr, cmtData1, cmtMask1, cmtData0, cmtMask0} = burstOut;

  //////////////////////////////////////////////////////////////////////////////
  // Array: one memory per lane and word, so each lane writes on its own select
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      logic [bmw_pkg::LANE_W-1:0] word0Mem [DEPTH];
      logic [bmw_pkg::LANE_W-1:0] word1Mem [DEPTH];

      always_ff @(posedge kClk) begin
        if (commit && !cmtMask0[gl]) begin
          word0Mem[cmtAddr] <= cmtData0[gl*bmw_pkg::LANE_W +: bmw_pkg::LANE_W];
        end
        if (commit && !cmtMask1[gl]) begin
          word1Mem[cmtAddr] <= cmtData1[gl*bmw_pkg::LANE_W +: bmw_pkg::LANE_W];
        end
      end

      assign arrWord0[gl*bmw_pkg::LANE_W +: bmw_pkg::LANE_W] = word0Mem[rdAddr_q];
      assign arrWord1[gl*bmw_pkg::LANE_W +: bmw_pkg::LANE_W] = word1Mem[rdAddr_q];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read fetch and event toggles toward the core
  always_ff @(posedge kClk or negedge linkRstB) begin
    if (!linkRstB) begin
      rdOut_q        <= 1'b0;
      rdData0_q      <= '0;
      rdData1_q      <= '0;
      dropToggle_q   <= 1'b0;
      commitToggle_q <= 1'b0;
      levelGray_q    <= '0;
    end else begin
      rdOut_q        <= rdPend_q;
      if (rdPend_q) begin
        rdData0_q <= arrWord0;
        rdData1_q <= arrWord1;
      end
      dropToggle_q   <= dropToggle_q ^ drop;
      commitToggle_q <= commitToggle_q ^ commit;
      levelGray_q    <= fifoLevel ^ (fifoLevel >> 1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Launch clocks: strap picks the input pair in single-clock mode
  assign launchClk  = singleClockMode ? kClk : cClk;
  assign launchClkN = singleClockMode ? kClkN : cClkN;

  // Word A+0 at the complement output rise of t+1
  always_ff @(posedge launchClkN or negedge rst_b) begin
    if (!rst_b) begin
      qFallOe_q   <= bmw_pkg::RST_OE;
      qFallData_q <= '0;
      hold1_q     <= '0;
    end else begin
      qFallOe_q <= rdOut_q;
      hold1_q   <= rdData1_q;
      if (rdOut_q) begin
        qFallData_q <= rdData0_q;
      end
    end
  end

  // Word A+1 at the output rise of t+2
  always_ff @(posedge launchClk or negedge rst_b) begin
    if (!rst_b) begin
      qRiseOe_q   <= bmw_pkg::RST_OE;
      qRiseData_q <= '0;
    end else begin
      qRiseOe_q <= qFallOe_q;
      if (qFallOe_q) begin
        qRiseData_q <= hold1_q;
      end
    end
  end

  assign qFallOe   = qFallOe_q;
  assign qFallData = qFallData_q;
  assign qRiseOe   = qRiseOe_q;
  assign qRiseData = qRiseData_q;

  //////////////////////////////////////////////////////////////////////////////
  // Core side: toggles and gray count pass two flip-flops first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dropSync1_q <= 1'b0;
      dropSync2_q <= 1'b0;
      dropSync3_q <= 1'b0;
      cmtSync1_q  <= 1'b0;
      cmtSync2_q  <= 1'b0;
      cmtSync3_q  <= 1'b0;
      lvlSync1_q  <= '0;
      lvlSync2_q  <= '0;
    end else begin
      dropSync1_q <= dropToggle_q;
      dropSync2_q <= dropSync1_q;
      dropSync3_q <= dropSync2_q;
      cmtSync1_q  <= commitToggle_q;
      cmtSync2_q  <= cmtSync1_q;
      cmtSync3_q  <= cmtSync2_q;
      lvlSync1_q  <= levelGray_q;
      lvlSync2_q  <= lvlSync1_q;
    end
  end

  // Overrun is sticky; a new drop beats a clear in the same cycle
  assign overrunFlag_d = (dropSync2_q ^ dropSync3_q) | (overrunFlag_q & ~overrunClear);

  // Gray to binary for the pending count
  always_comb begin
    pending_d = '0;
    for (int i = LVL_W - 1; i >= 0; i--) begin
      if (i == LVL_W - 1) begin
        pending_d[i] = lvlSync2_q[i];
      end else begin
        pending_d[i] = pending_d[i+1] ^ lvlSync2_q[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overrunFlag_q <= 1'b0;
      writeCommit_q <= 1'b0;
      pending_q     <= '0;
    end else begin
      overrunFlag_q <= overrunFlag_d;
      writeCommit_q <= cmtSync2_q ^ cmtSync3_q;
      pending_q     <= pending_d;
    end
  end

  assign overrunFlag   = overrunFlag_q;
  assign writeCommit   = writeCommit_q;
  assign pendingBursts = pending_q;

endmodule : bmw_write_path

// ===== rtl/bmw_pkg.sv
// Purpose: Shared constants for the byte-masked burst write path
// Assumes: Two-word bursts, 9-bit lanes, link clock pair separate from core_clk
// Notes:   Array depth is a plain default; real depth is set at the top module
package bmw_pkg;

  // Lane layout
  localparam int LANE_W         = 9;
  localparam int DATA_W_DEFAULT = 18;
  localparam int ADDR_W_DEFAULT = 8;

  // Burst layout: two words per location, A+0 then A+1
  localparam int BURST_WORDS = 2;
  localparam int WORD0_IDX   = 0;
  localparam int WORD1_IDX   = 1;

  // Write burst buffer
  localparam int FIFO_DEPTH = 8;

  // Synchroniser length for toggles and gray counts into core_clk
  localparam int SYNC_STAGES = 2;

  // Reset values
  localparam logic RST_SEL_N = 1'b1;
  localparam logic RST_OE    = 1'b0;

endpackage : bmw_pkg

// ===== rtl/bmw_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock; WIDTH and DEPTH shape the storage, DEPTH a power of two
// Notes:   Full drops inReady, empty drops outValid; level shows the word count
module bmw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstB,
  // Fill side
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  // Drain side
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  // Occupancy
  output logic [$clog2(DEPTH):0]          level
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  //////////////////////////////////////////////////////////////////////////////
  // Flags
  assign full     = (wrPtr_q[PW] != rdPtr_q[PW]) && (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign push     = inValid & ~full;
  assign pop      = outReady & ~empty;
  assign outData  = store[rdPtr_q[PW-1:0]];
  assign level    = wrPtr_q - rdPtr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pointers
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr_q[PW-1:0]] <= inData;
    end
  end

endmodule : bmw_fifo

// ===== dv/bmw_write_path_monitor.sv
// Purpose: Port checker for the burst write path
// Assumes: Output clock pair runs in phase with the input pair
// Notes:   Bound from the bench top file
module bmw_write_path_monitor (
  // Core side
  input wire logic                                  core_clk,
  input wire logic                                  rst_b,
  input wire logic                                  overrunClear,
  input wire logic                                  overrunFlag,
  input wire logic                                  writeCommit,
  input wire logic [$clog2(bmw_pkg::FIFO_DEPTH):0]  pendingBursts,
  // Link side
  input wire logic                                  kClk,
  input wire logic                                  read_port_select_n,
  input wire logic                                  qFallOe,
  input wire logic                                  qRiseOe
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////
  // Read launch steps
  sequence readIssue;
    !read_port_select_n;
  endsequence
  sequence fallThenRise;
    qFallOe ##1 qRiseOe;
  endsequence

  ////////////////////////////////////////////////////////////////
  reset_quiet_a: assert property (@(posedge core_clk) !rst_b |-> !(qFallOe || qRiseOe || writeCommit || overrunFlag))
    else $error("outputs active during reset");
  read_answer_a: assert property (@(posedge kClk) disable iff (!rst_b) readIssue |-> ##2 fallThenRise)
    else $error("read words not launched on time");
  fall_cause_a: assert property (@(posedge kClk) disable iff (!rst_b) qFallOe |-> !$past(read_port_select_n, 2))
    else $error("first word enable without a read");
  rise_cause_a: assert property (@(posedge kClk) disable iff (!rst_b) qRiseOe |-> !$past(read_port_select_n, 3))
    else $error("second word enable without a read");
  commit_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b) writeCommit |=> !writeCommit [*3])
    else $error("commit pulse too long");
  pending_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b) pendingBursts <= bmw_pkg::FIFO_DEPTH)
    else $error("pending count above buffer depth");
  overrun_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) overrunFlag && !overrunClear |=> overrunFlag)
    else $error("overrun flag lost");
  overrun_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b) $fell(overrunFlag) |-> $past(overrunClear))
    else $error("overrun flag fell without clear");
endmodule : bmw_write_path_monitor

// ===== dv/bmw_ctrl_model.sv
// Purpose: Memory controller driving the link of the burst write path
// Assumes: Zero skew between input and output clock pairs
// Notes:   Released lines show the inverse of their last value
module bmw_ctrl_model #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 8
) (
  // Strap
  input  wire logic                      singleClk,
  // Clocks
  output logic                           kClk,
  output logic                           kClkN,
  output logic                           cClk,
  output logic                           cClkN,
  // Request lines
  output logic                           read_port_select_n,
  output logic                           write_port_select_n,
  output logic [ADDR_W-1:0]              addrIn,
  output logic [DATA_W-1:0]              dataIn,
  output logic [DATA_W/9-1:0]            lane_write_select_n,
  // Read words
  input  wire logic [DATA_W-1:0]         qRiseData,
  input  wire logic                      qRiseOe,
  input  wire logic [DATA_W-1:0]         qFallData,
  input  wire logic                      qFallOe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    kClk = 1'b1;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addrIn = '0;
    dataIn = '0;
    lane_write_select_n = '1;
  end
  always #62.5 kClk = ~kClk;
  assign kClkN = ~kClk;
  // Output pair tied high in single-clock mode
  assign cClk  = singleClk ? 1'b1 : kClk;
  assign cClkN = singleClk ? 1'b1 : kClkN;

  ////////////////////////////////////////////////////////////////
  // Write burst, optionally with a read on the same edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                    input logic [DATA_W/9-1:0] m0, m1, input logic rd);
    @(posedge kClkN);
    #31;
    write_port_select_n = 1'b0;
    read_port_select_n = !rd;
    addrIn = a;
    dataIn = d0;
    lane_write_select_n = m0;
    @(posedge kClk);
    #31;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    dataIn = d1;
    lane_write_select_n = m1;
  endtask : wr

  // Release data lines after the hold
  task automatic idle;
    @(posedge kClkN);
    #31;
    addrIn = ~addrIn;
    dataIn = ~dataIn;
    lane_write_select_n = ~lane_write_select_n;
  endtask : idle

  // Read burst, bus floats when not driven
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q0, q1);
    @(posedge kClkN);
    #31;
    read_port_select_n = 1'b0;
    addrIn = a;
    @(posedge kClk);
    #31;
    read_port_select_n = 1'b1;
    addrIn = ~a;
    @(posedge kClk);
    // Zero skew: input pair edges stand for either launch pair
    @(posedge kClkN);
    #5;
    q0 = qFallOe ? qFallData : {DATA_W{1'bz}};
    @(posedge kClk);
    #5;
    q1 = qRiseOe ? qRiseData : {DATA_W{1'bz}};
  endtask : rd
endmodule : bmw_ctrl_model

// ===== dv/bmw_write_path_tb_top.sv
// Purpose: Self-checking bench for the burst write path
// Assumes: 18-bit width, controller model on the link
// Notes:   Rows hold lane masks and the words expected back
module bmw_write_path_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic [1:0] m0; logic [1:0] m1; logic [17:0] e0; logic [17:0] e1;} bmw_row_t;
  localparam bmw_row_t ROWS [5] = '{'{2'h0, 2'h3, 18'h15A3C, 18'h3FFFF}, '{2'h1, 2'h2, 18'h15BFF, 18'h3FFC3},
                                    '{2'h2, 2'h1, 18'h3FE3C, 18'h2A5FF}, '{2'h3, 2'h0, 18'h3FFFF, 18'h2A5C3},
                                    '{2'h0, 2'h0, 18'h15A3C, 18'h2A5C3}};

  logic                                  core_clk     = 1'b0;
  logic                                  rst_b        = 1'b1;
  logic                                  singleClockMode = 1'b0;
  logic                                  overrunClear = 1'b0;
  logic                                  overrunFlag, writeCommit, kClk, kClkN, cClk, cClkN;
  logic                                  read_port_select_n, write_port_select_n, qRiseOe, qFallOe;
  logic [$clog2(bmw_pkg::FIFO_DEPTH):0]  pendingBursts;
  logic [7:0]                            addrIn;
  logic [17:0]                           dataIn, qRiseData, qFallData;
  logic [1:0]                            lane_write_select_n;
  int                                    mismatches = 0;
  int                                    checked    = 0;
  int                                    commits    = 0;

  always #12.5 core_clk = ~core_clk;

  // Commit pulses seen by the core
  always @(negedge core_clk) begin
    if (writeCommit === 1'b1) commits++;
  end

  bmw_write_path i_bmw_write_path (.core_clk(core_clk), .rst_b(rst_b), .overrunClear(overrunClear),
    .overrunFlag(overrunFlag), .writeCommit(writeCommit), .pendingBursts(pendingBursts),
    .singleClockMode(singleClockMode),
    .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addrIn(addrIn), .dataIn(dataIn),
    .lane_write_select_n(lane_write_select_n), .qRiseData(qRiseData), .qRiseOe(qRiseOe),
    .qFallData(qFallData), .qFallOe(qFallOe));

  bmw_ctrl_model i_bmw_ctrl_model (.singleClk(singleClockMode), .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
    .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n), .addrIn(addrIn),
    .dataIn(dataIn), .lane_write_select_n(lane_write_select_n), .qRiseData(qRiseData), .qRiseOe(qRiseOe),
    .qFallData(qFallData), .qFallOe(qFallOe));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [17:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic drain;
    int n;
    repeat (3) @(posedge kClk);
    for (n = 0; n < 200 && pendingBursts !== '0; n++) @(negedge core_clk);
    if (n == 200) begin
      mismatches++;
      $display("mismatch drain expected 0 seen %h", pendingBursts);
      finish_test();
    end
    repeat (20) @(negedge core_clk);
  endtask : drain

  initial begin
    #2000000;
    mismatches++;
    $display("mismatch watchdog expected end seen hang");
    finish_test();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [17:0] q0, q1;
    // Clean falling edge so every async reset fires
    #1 rst_b = 1'b0;
    repeat (20) @(negedge core_clk);
    check("reset outputs", 18'h0, {10'h0, qFallOe, qRiseOe, overrunFlag, writeCommit, pendingBursts});
    rst_b = 1'b1;
    repeat (4) @(posedge kClk);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      i_bmw_ctrl_model.wr(8'(i), 18'h3FFFF, 18'h3FFFF, 2'h0, 2'h0, 1'b0);
      i_bmw_ctrl_model.wr(8'(i), 18'h15A3C, 18'h2A5C3, ROWS[i].m0, ROWS[i].m1, 1'b0);
      i_bmw_ctrl_model.idle();
      drain();
      i_bmw_ctrl_model.rd(8'(i), q0, q1);
      check("first word", ROWS[i].e0, q0);
      check("second word", ROWS[i].e1, q1);
      $display("row %0d done", i);
    end
    check("commit count", 18'h0000A, 18'(commits));
    for (int i = 0; i < 12; i++) i_bmw_ctrl_model.wr(8'h04, 18'h00000, 18'h00000, 2'h3, 2'h3, 1'b1);
    i_bmw_ctrl_model.idle();
    @(negedge core_clk);
    check("overrun flag", 18'h1, {17'h0, overrunFlag});
    drain();
    check("overrun commits", 18'h00012, 18'(commits));
    i_bmw_ctrl_model.rd(8'h04, q0, q1);
    check("masked first word", 18'h15A3C, q0);
    check("masked second word", 18'h2A5C3, q1);
    overrunClear = 1'b1;
    @(negedge core_clk);
    overrunClear = 1'b0;
    @(negedge core_clk);
    check("overrun cleared", 18'h0, {17'h0, overrunFlag});
    $display("overrun test done");
    rst_b = 1'b0;
    singleClockMode = 1'b1;
    repeat (20) @(negedge core_clk);
    check("mid reset outputs", 18'h0, {10'h0, qFallOe, qRiseOe, overrunFlag, writeCommit, pendingBursts});
    rst_b = 1'b1;
    repeat (4) @(posedge kClk);
    i_bmw_ctrl_model.rd(8'h04, q0, q1);
    check("single clock first word", 18'h15A3C, q0);
    check("single clock second word", 18'h2A5C3, q1);
    $display("single clock test done");
    finish_test();
  end
endmodule : bmw_write_path_tb_top

bind bmw_write_path bmw_write_path_monitor i_bmw_write_path_monitor (.core_clk(core_clk), .rst_b(rst_b),
  .overrunClear(overrunClear), .overrunFlag(overrunFlag), .writeCommit(writeCommit),
  .pendingBursts(pendingBursts), .kClk(kClk), .read_port_select_n(read_port_select_n),
  .qFallOe(qFallOe), .qRiseOe(qRiseOe));
